// >>> core/vfd_mux_pkg.sv
// vfd_mux_pkg: command addresses, field limits, reset values and timing counts
// assumes a 50 MHz system clock standing in for the multiplex oscillator
package vfd_mux_pkg;

    // ------------------------------------------------------------------
    // command frame layout
    // ------------------------------------------------------------------
    localparam int CMD_W = 16;
    localparam int READ_BIT = 15;
    localparam int ADDR_HI = 14;
    localparam int ADDR_LO = 8;
    localparam int DATA_HI = 7;
    localparam int BYTE_W = 8;

    // ------------------------------------------------------------------
    // command addresses
    // ------------------------------------------------------------------
    localparam logic [6:0] ADDR_NO_OPERATION = 7'h00;
    localparam logic [6:0] ADDR_INTENSITY = 7'h02;
    localparam logic [6:0] ADDR_GRIDS = 7'h03;
    localparam logic [6:0] ADDR_BLANK_POLARITY = 7'h05;
    localparam logic [6:0] ADDR_SHIFT_LIMIT = 7'h0E;

    // ------------------------------------------------------------------
    // limits and reset values
    // ------------------------------------------------------------------
    localparam logic [7:0] GRIDS_MAX = 8'h2F;
    localparam logic [7:0] SHIFT_LIMIT_MAX = 8'h79;
    localparam logic [7:0] GRIDS_RST = 8'h00;
    localparam logic [7:0] SHIFT_LIMIT_RST = 8'h01;
    localparam logic [7:0] INTENSITY_RST = 8'h00;
    localparam logic [7:0] BLANK_POLARITY_RST = 8'h00;
    localparam logic [3:0] DUTY_MIN = 4'h1;
    localparam logic [3:0] DUTY_MAX = 4'hF;

    // ------------------------------------------------------------------
    // timing
    // ------------------------------------------------------------------
    localparam int CLK_NS = 20;
    localparam int MUX_PERIOD_NS = 100000;
    localparam int SLOTS = 16;
    localparam int SIXTEENTH_CYC = (MUX_PERIOD_NS / SLOTS + CLK_NS - 1) / CLK_NS;
    localparam int TUBE_CLK_NS = 500;
    localparam int TUBE_HALF_CYC = (TUBE_CLK_NS / 2 + CLK_NS - 1) / CLK_NS;

    // ------------------------------------------------------------------
    // tube driver sequencer states
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_LOAD = 3'b010,
        ST_SHIFT = 3'b100
    } tube_state_t;

endpackage : vfd_mux_pkg

// >>> core/vfd_multiplex_serial_ctrl.sv
// vfd_multiplex_serial_ctrl: host serial command port and tube multiplex engine
// assumes host_sclk only toggles around frames and a shift-register tube driver
//
// How it works
// - each frame is 16 bits, address byte on top, data byte below.
// - serial input reappears on the serial output 15.5 clocks later.
// - input shifts on rising clock only while chip select is low.
// - chip select rising copies the shift register to a latch, then executes.
// - over-length frames keep only the last 16 bits received.
// - top bit set means read; next seven bits address, low byte ignored.
// - read value goes to shift register low byte, returned during next frame.
// - tube shift clock runs at half the oscillator rate.
// - each grid stream carries shift-limit plus one bits, at most 122.
// - tube data changes only on falling tube clock edges and, with the clock low, when the load phase ends.
// - latch strobe high makes driver latch transparent, low holds it.
// - blank output level follows the polarity setting; default high blanks.
// - next grid pattern is shifted out during the current grid slot.
// - latch strobe pulses at the start of every grid period.
// - grid count 1 to 48; writes above 0x2F store 0x2F.
// - after a grid count write, blank one full scan, then resume.
// - intensity low nibble sets enabled time from 1/16 to 15/16.
// - every grid period starts with at least 1/16 blanked.
// - no_operation writes change nothing.
// - grid period is 100 us at a 4 MHz oscillator.
// - the serial output is always driven, never high impedance.
`timescale 1ns/1ps
`default_nettype none

module vfd_multiplex_serial_ctrl #(
    parameter int SIXTEENTH_CYC = vfd_mux_pkg::SIXTEENTH_CYC,
    parameter int TUBE_HALF_CYC = vfd_mux_pkg::TUBE_HALF_CYC
) (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic host_sclk,
    input wire logic host_cs_n,
    input wire logic host_din,
    output logic general_out_a,
    output logic tube_shift_clock,
    output logic tube_serial_out,
    output logic tube_latch_strobe,
    output logic tube_blank_out
);

    localparam int SUB_W = $clog2(SIXTEENTH_CYC + 1);
    localparam int HALF_W = $clog2(TUBE_HALF_CYC + 1);

    // ------------------------------------------------------------------
    // functions
    // ------------------------------------------------------------------
    function automatic logic [7:0] clamp8(input logic [7:0] v, input logic [7:0] lim);
        clamp8 = (v > lim) ? lim : v;
    endfunction : clamp8

    function automatic logic [5:0] grid_inc(input logic [5:0] g, input logic [7:0] last);
        grid_inc = (g >= last[5:0]) ? 6'h00 : g + 6'h01;
    endfunction : grid_inc

    // ------------------------------------------------------------------
    // host clock domain: shift register and serial output
    // ------------------------------------------------------------------
    logic rst_s1_q;
    logic rst_s2_q;
    logic [15:0] sr_q;
    logic [15:0] sr_d;
    logic [4:0] nbit_q;
    logic [4:0] shifts_d;
    logic idle_q;
    logic dout_q;
    logic tog_s1_q;
    logic tog_s2_q;
    logic ack_q;
    logic rd_load;
    logic rd_tog_q;
    logic [7:0] rd_byte_q;

    assign shifts_d = idle_q ? 5'h01 : ((nbit_q == 5'h1F) ? nbit_q : nbit_q + 5'h01);
    assign rd_load = (tog_s2_q != ack_q) && (shifts_d <= 5'h08);

    always_comb begin
        sr_d = {sr_q[14:0], host_din};
        if (rd_load) begin
            for (int i = 0; i < vfd_mux_pkg::BYTE_W; i++) begin
                sr_d[shifts_d[3:0] + 4'(i)] = rd_byte_q[i];
            end
        end
    end

    always_ff @(posedge host_sclk) begin
        rst_s1_q <= srst;
        rst_s2_q <= rst_s1_q;
    end

    always_ff @(posedge host_sclk) begin
        if (rst_s2_q) begin
            sr_q <= 16'h0000;
            nbit_q <= 5'h00;
            tog_s1_q <= 1'b0;
            tog_s2_q <= 1'b0;
            ack_q <= 1'b0;
        end else begin
            tog_s1_q <= rd_tog_q;
            tog_s2_q <= tog_s1_q;
            if (!host_cs_n) begin
                sr_q <= sr_d;
                nbit_q <= shifts_d;
                if (rd_load) begin
                    ack_q <= tog_s2_q;
                end
            end
        end
    end

    // half-cycle delay onto the output gives the chain latency
    always_ff @(negedge host_sclk) begin
        if (rst_s2_q) begin
            idle_q <= 1'b1;
            dout_q <= 1'b0;
        end else begin
            idle_q <= host_cs_n;
            dout_q <= sr_q[15];
        end
    end

    assign general_out_a = dout_q;

    // ------------------------------------------------------------------
    // system domain: frame latch and command execution
    // ------------------------------------------------------------------
    logic cs_s1_q;
    logic cs_s2_q;
    logic cs_s3_q;
    logic exec_q;
    logic [15:0] latch_q;
    logic cs_rise;
    logic is_read;
    logic do_write;
    logic do_read;
    logic [6:0] cmd_addr;
    logic [7:0] cmd_data;
    logic [7:0] rd_value;
    logic [7:0] intensity_q;
    logic [7:0] grids_q;
    logic [7:0] polarity_q;
    logic [7:0] shift_limit_q;
    logic wr_intensity;
    logic wr_grids;
    logic wr_polarity;
    logic wr_shift_limit;

    assign cs_rise = cs_s2_q & ~cs_s3_q;
    assign is_read = latch_q[vfd_mux_pkg::READ_BIT];
    assign do_write = exec_q & ~is_read;
    assign do_read = exec_q & is_read;
    assign cmd_addr = latch_q[vfd_mux_pkg::ADDR_HI:vfd_mux_pkg::ADDR_LO];
    assign cmd_data = latch_q[vfd_mux_pkg::DATA_HI:0];
    // no_operation address matches no register and so writes nothing
    assign wr_intensity = do_write && (cmd_addr == vfd_mux_pkg::ADDR_INTENSITY);
    assign wr_grids = do_write && (cmd_addr == vfd_mux_pkg::ADDR_GRIDS);
    assign wr_polarity = do_write && (cmd_addr == vfd_mux_pkg::ADDR_BLANK_POLARITY);
    assign wr_shift_limit = do_write && (cmd_addr == vfd_mux_pkg::ADDR_SHIFT_LIMIT);
    assign rd_value = (cmd_addr == vfd_mux_pkg::ADDR_INTENSITY) ? intensity_q :
                      (cmd_addr == vfd_mux_pkg::ADDR_GRIDS) ? grids_q :
                      (cmd_addr == vfd_mux_pkg::ADDR_BLANK_POLARITY) ? polarity_q :
                      (cmd_addr == vfd_mux_pkg::ADDR_SHIFT_LIMIT) ? shift_limit_q : 8'h00;

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            cs_s1_q <= 1'b1;
            cs_s2_q <= 1'b1;
            cs_s3_q <= 1'b1;
            exec_q <= 1'b0;
            latch_q <= 16'h0000;
        end else begin
            cs_s1_q <= host_cs_n;
            cs_s2_q <= cs_s1_q;
            cs_s3_q <= cs_s2_q;
            exec_q <= cs_rise;
            if (cs_rise) begin
                latch_q <= sr_q;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            rd_byte_q <= 8'h00;
            rd_tog_q <= 1'b0;
        end else if (do_read) begin
            rd_byte_q <= rd_value;
            rd_tog_q <= ~rd_tog_q;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            intensity_q <= vfd_mux_pkg::INTENSITY_RST;
            grids_q <= vfd_mux_pkg::GRIDS_RST;
            polarity_q <= vfd_mux_pkg::BLANK_POLARITY_RST;
            shift_limit_q <= vfd_mux_pkg::SHIFT_LIMIT_RST;
        end else begin
            if (wr_intensity) begin
                intensity_q <= cmd_data;
            end
            if (wr_grids) begin
                grids_q <= clamp8(cmd_data, vfd_mux_pkg::GRIDS_MAX);
            end
            if (wr_polarity) begin
                polarity_q <= cmd_data;
            end
            if (wr_shift_limit) begin
                shift_limit_q <= clamp8(cmd_data, vfd_mux_pkg::SHIFT_LIMIT_MAX);
            end
        end
    end

    // ------------------------------------------------------------------
    // multiplex timebase: sixteenths of a grid period
    // ------------------------------------------------------------------
    logic [SUB_W-1:0] sub_q;
    logic [3:0] slot_q;
    logic [5:0] grid_q;
    logic sub_wrap;
    logic period_start;
    logic scan_start;
    logic [5:0] grid_d;
    logic pend_q;
    logic hold_q;
    logic [3:0] duty;
    logic window;
    logic blank_d;

    assign sub_wrap = (sub_q == SUB_W'(SIXTEENTH_CYC - 1));
    assign period_start = sub_wrap && (slot_q == 4'hF);
    assign grid_d = grid_inc(grid_q, grids_q);
    assign scan_start = period_start && (grid_d == 6'h00);
    assign duty = (intensity_q[3:0] < vfd_mux_pkg::DUTY_MIN) ? vfd_mux_pkg::DUTY_MIN :
                  intensity_q[3:0];
    assign window = (slot_q >= 4'h1) && (slot_q <= duty) && (duty <= vfd_mux_pkg::DUTY_MAX);
    assign blank_d = ~window | hold_q;

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            sub_q <= '0;
            slot_q <= 4'h0;
            grid_q <= 6'h00;
        end else begin
            sub_q <= sub_wrap ? '0 : sub_q + SUB_W'(1);
            if (sub_wrap) begin
                slot_q <= slot_q + 4'h1;
            end
            if (period_start) begin
                grid_q <= grid_d;
            end
        end
    end

    // grid count write blanks the whole next scan; a write wins over the clear
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            pend_q <= 1'b0;
            hold_q <= 1'b0;
            tube_blank_out <= 1'b1;
        end else begin
            pend_q <= wr_grids | (pend_q & ~scan_start);
            if (scan_start) begin
                hold_q <= pend_q;
            end
            tube_blank_out <= blank_d ^ polarity_q[0];
        end
    end

    // ------------------------------------------------------------------
    // tube driver sequencer: load strobe then shift next grid
    // ------------------------------------------------------------------
    vfd_mux_pkg::tube_state_t state_q;
    logic [HALF_W-1:0] half_q;
    logic [6:0] bit_q;
    logic [5:0] tgt_q;
    logic half_wrap;
    logic last_bit;
    logic [6:0] bit_d;

    assign half_wrap = (half_q == HALF_W'(TUBE_HALF_CYC - 1));
    assign last_bit = (bit_q == shift_limit_q[6:0]);
    assign bit_d = bit_q + 7'h01;

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            state_q <= vfd_mux_pkg::ST_IDLE;
            half_q <= '0;
            bit_q <= 7'h00;
            tgt_q <= 6'h00;
            tube_shift_clock <= 1'b0;
            tube_serial_out <= 1'b0;
            tube_latch_strobe <= 1'b0;
        end else if (period_start) begin
            state_q <= vfd_mux_pkg::ST_LOAD;
            half_q <= '0;
            tgt_q <= grid_inc(grid_d, grids_q);
            tube_shift_clock <= 1'b0;
            tube_serial_out <= 1'b0;
            tube_latch_strobe <= 1'b1;
        end else begin
            half_q <= half_wrap ? '0 : half_q + HALF_W'(1);
            case (state_q)
                vfd_mux_pkg::ST_LOAD: begin
                    if (half_wrap) begin
                        state_q <= vfd_mux_pkg::ST_SHIFT;
                        tube_latch_strobe <= 1'b0;
                        bit_q <= 7'h00;
                        tube_serial_out <= (tgt_q == 6'h00);
                    end
                end
                vfd_mux_pkg::ST_SHIFT: begin
                    if (half_wrap && !tube_shift_clock) begin
                        tube_shift_clock <= 1'b1;
                    end else if (half_wrap) begin
                        tube_shift_clock <= 1'b0;
                        if (last_bit) begin
                            state_q <= vfd_mux_pkg::ST_IDLE;
                            tube_serial_out <= 1'b0;
                        end else begin
                            bit_q <= bit_d;
                            tube_serial_out <= (bit_d == {1'b0, tgt_q});
                        end
                    end
                end
                vfd_mux_pkg::ST_IDLE: begin
                    tube_shift_clock <= 1'b0;
                end
                default: begin
                    state_q <= vfd_mux_pkg::ST_IDLE;
                end
            endcase
        end
    end

endmodule : vfd_multiplex_serial_ctrl

`default_nettype wire

// >>> bench/vfd_mux_asserts.sv
// vfd_mux_asserts: port checks of the host serial port and the tube link
// assumes a bind onto vfd_multiplex_serial_ctrl with its parameters handed on
`timescale 1ns/1ps
`default_nettype none
module vfd_mux_asserts #(
    parameter int SIXTEENTH_CYC = 313,
    parameter int TUBE_HALF_CYC = 13
) (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic host_sclk,
    input wire logic host_cs_n,
    input wire logic host_din,
    input wire logic general_out_a,
    input wire logic tube_shift_clock,
    input wire logic tube_serial_out,
    input wire logic tube_latch_strobe,
    input wire logic tube_blank_out
);
    // ----------------------------------------------------------------
    // helper counters
    // ----------------------------------------------------------------
    logic strobe_q, seen_q;
    logic [15:0] per_q;
    logic [7:0] hi_q, str_q;
    logic [3:0] quiet_q, bit_q;
    logic [4:0] tot_q = 5'h00;
    wire logic rise = tube_latch_strobe & ~strobe_q;
    always_ff @(posedge sys_clk) begin
        strobe_q <= tube_latch_strobe;
        seen_q <= ~srst & (seen_q | rise);
        per_q <= (srst | rise) ? 16'h0001 : per_q + 16'h0001;
        hi_q <= tube_shift_clock ? hi_q + 8'h01 : 8'h00;
        str_q <= tube_latch_strobe ? str_q + 8'h01 : 8'h00;
        quiet_q <= (srst | ~host_cs_n) ? 4'h0 : quiet_q + {3'h0, quiet_q != 4'hF};
    end
    always_ff @(posedge host_sclk or posedge host_cs_n) begin
        if (host_cs_n) begin
            bit_q <= 4'h0;
        end else begin
            bit_q <= bit_q + {3'h0, bit_q != 4'hF};
        end
    end
    always_ff @(posedge host_sclk) begin
        tot_q <= tot_q + {4'h0, tot_q != 5'h1F};
    end
    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    a_strobe_width: assert property (@(posedge sys_clk) disable iff (srst)
        $fell(tube_latch_strobe) |-> str_q == TUBE_HALF_CYC) else $error("strobe width wrong");
    a_strobe_first: assert property (@(posedge sys_clk) disable iff (srst)
        tube_latch_strobe && !rise |-> per_q < TUBE_HALF_CYC) else $error("strobe off start");
    a_load_no_shift: assert property (@(posedge sys_clk) disable iff (srst)
        tube_latch_strobe |-> !tube_shift_clock) else $error("shift during load");
    a_clock_high: assert property (@(posedge sys_clk) disable iff (srst)
        $fell(tube_shift_clock) |-> hi_q == TUBE_HALF_CYC) else $error("tube clock high time");
    a_data_edge: assert property (@(posedge sys_clk) disable iff (srst)
        $changed(tube_serial_out) |-> !tube_shift_clock) else $error("tube data moved");
    a_period_len: assert property (@(posedge sys_clk) disable iff (srst)
        rise && seen_q |-> per_q == 16 * SIXTEENTH_CYC) else $error("grid period length");
    a_early_blank: assert property (@(posedge sys_clk) disable iff (srst)
        per_q >= 2 && per_q < SIXTEENTH_CYC && quiet_q == 4'hF |-> $stable(tube_blank_out))
        else $error("blank moved in first slot");
    a_chain_delay: assert property (@(posedge host_sclk) disable iff (srst)
        !host_cs_n && bit_q < 4'h8 && tot_q == 5'h1F |-> general_out_a == $past(host_din, 16))
        else $error("chain output delay");
    c_period: cover property (@(posedge sys_clk) rise && seen_q);
    c_enable: cover property (@(posedge sys_clk) $changed(tube_blank_out));
    c_long: cover property (@(posedge host_sclk) !host_cs_n && bit_q == 4'hF);
endmodule : vfd_mux_asserts
`default_nettype wire

// >>> bench/tube_driver_model.sv
// tube_driver_model: shift-register tube driver with output latch
// assumes clock, data and strobe straight from the design's tube link
`timescale 1ns/1ps
`default_nettype none
module tube_driver_model (
    input wire logic tube_shift_clock,
    input wire logic tube_serial_out,
    input wire logic tube_latch_strobe,
    output logic [7:0] last_count,
    output logic [127:0] latch_q
);
    logic [127:0] shift_q = 128'h0;
    logic [7:0] count_q = 8'h00;
    always @(posedge tube_shift_clock or posedge tube_latch_strobe) begin
        if (tube_latch_strobe) begin
            last_count <= count_q;
            count_q <= 8'h00;
        end else begin
            shift_q <= {shift_q[126:0], tube_serial_out};
            count_q <= count_q + 8'h01;
        end
    end
    always @* begin
        if (tube_latch_strobe) begin
            latch_q = shift_q;
        end
    end
endmodule : tube_driver_model
`default_nettype wire

// >>> bench/vfd_multiplex_serial_ctrl_bench.sv
// vfd_multiplex_serial_ctrl_bench: host frames, readback and tube link timing
// assumes the design under core/ and the tube driver model beside this file
`timescale 1ns/1ps
`default_nettype none
module vfd_multiplex_serial_ctrl_bench;
    localparam int SIXT = 40;
    localparam int PER = 16 * SIXT;
    typedef struct packed {
        logic [15:0] wr;
        logic [6:0] addr;
        logic [7:0] exp;
    } row_t;
    row_t rows [11] = '{'{16'h0305, 7'h03, 8'h05}, '{16'h0330, 7'h03, 8'h2F},
        '{16'h03FF, 7'h03, 8'h2F}, '{16'h0E7A, 7'h0E, 8'h79}, '{16'h0E05, 7'h0E, 8'h05},
        '{16'h020A, 7'h02, 8'h0A}, '{16'h0033, 7'h02, 8'h0A}, '{16'h0501, 7'h05, 8'h01},
        '{16'h0500, 7'h05, 8'h00}, '{16'h0302, 7'h03, 8'h02}, '{16'h0000, 7'h7F, 8'h00}};
    logic [7:0] lvl [4] = '{8'h00, 8'h04, 8'hF7, 8'h0F};
    int slots [4] = '{1, 4, 7, 15};
    logic sys_clk = 1'b0;
    logic srst = 1'b1;
    logic host_sclk = 1'b0;
    logic host_cs_n = 1'b1;
    logic host_din = 1'b0;
    logic general_out_a, tube_shift_clock, tube_serial_out, tube_latch_strobe, tube_blank_out;
    logic [7:0] last_count;
    logic [127:0] pattern;
    logic [15:0] rx, cnt;
    logic pol;
    int err_total = 0;
    int n_compared = 0;
    vfd_multiplex_serial_ctrl #(.SIXTEENTH_CYC(SIXT), .TUBE_HALF_CYC(2)) DUT (
        .sys_clk(sys_clk), .srst(srst), .host_sclk(host_sclk), .host_cs_n(host_cs_n),
        .host_din(host_din), .general_out_a(general_out_a), .tube_shift_clock(tube_shift_clock),
        .tube_serial_out(tube_serial_out), .tube_latch_strobe(tube_latch_strobe),
        .tube_blank_out(tube_blank_out));
    tube_driver_model far_end (.tube_shift_clock(tube_shift_clock),
        .tube_serial_out(tube_serial_out), .tube_latch_strobe(tube_latch_strobe),
        .last_count(last_count), .latch_q(pattern));
    // ----------------------------------------------------------------
    // shared tasks
    // ----------------------------------------------------------------
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic results();
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : results
    task automatic frame(input logic [31:0] w, input int n);
        repeat (10) @(posedge sys_clk);
        host_cs_n <= 1'b0;
        #16;
        for (int i = n - 1; i >= 0; i--) begin
            host_din <= w[i];
            #16;
            rx = {rx[14:0], general_out_a};
            host_sclk <= 1'b1;
            #16;
            if (i > 0) begin
                host_sclk <= 1'b0;
            end
        end
        host_cs_n <= 1'b1;
        #16;
        host_sclk <= 1'b0;
    endtask : frame
    task automatic wait_level(input logic v);
        int k;
        k = 0;
        while (tube_latch_strobe !== v && k < 2000) begin
            @(posedge sys_clk);
            #1;
            k++;
        end
        if (k >= 2000) begin
            check("strobe wait", 16'h0, 16'h1);
            results();
        end
    endtask : wait_level
    task automatic measure(output logic [15:0] n);
        repeat (8) @(posedge sys_clk);
        wait_level(1'b0);
        wait_level(1'b1);
        n = 16'h0;
        repeat (PER) begin
            @(posedge sys_clk);
            #1;
            n += {15'h0, tube_blank_out === pol};
        end
    endtask : measure
    // ----------------------------------------------------------------
    // clocks and main sequence
    // ----------------------------------------------------------------
    initial begin
        forever #10 sys_clk = ~sys_clk;
    end
    initial begin
        repeat (5) begin
            #16 host_sclk = 1'b1;
            #16 host_sclk = 1'b0;
        end
    end
    initial begin
        repeat (5) @(posedge sys_clk);
        #1;
        check("blank in reset", tube_blank_out, 1'b1);
        check("strobe in reset", tube_latch_strobe, 1'b0);
        check("dout in reset", general_out_a, 1'b0);
        @(posedge sys_clk);
        srst <= 1'b0;
        foreach (rows[i]) begin
            frame(rows[i].wr, 16);
            frame({16'h0, 1'b1, rows[i].addr, 8'h00}, 16);
            frame(32'h0, 16);
            check("echo address", rx[14:8], rows[i].addr);
            check("read value", rx[7:0], rows[i].exp);
            $display("row %0d done", i);
        end
        frame({12'h000, 4'hF, 16'h020C}, 20);
        frame({16'h0, 16'h8200}, 16);
        frame(32'h0, 16);
        check("long frame", rx[7:0], 8'h0C);
        frame({16'h0C01, 16'h0000}, 32);
        check("chain pass", rx, 16'h0C01);
        $display("frame length tests done");
        // let the blanked scan after the last grid count write run out
        repeat (4000) @(posedge sys_clk);
        pol = 1'b0;
        measure(cnt);
        check("stream bits", last_count, 8'h06);
        for (int j = 0; j < 4; j++) begin
            pol = j[0];
            frame({24'h000002, lvl[j]}, 16);
            frame({16'h0, 8'h05, 7'h00, pol}, 16);
            measure(cnt);
            measure(cnt);
            check("enabled time", cnt, 16'(slots[j] * SIXT));
        end
        $display("duty tests done");
        frame(32'h0300, 16);
        measure(cnt);
        check("clear cycle", cnt, 16'h0);
        measure(cnt);
        check("after clear", cnt, 16'(15 * SIXT));
        check("stream pattern", {10'h000, pattern[5:0]}, 16'h0020);
        $display("grid clear test done");
        results();
    end
endmodule : vfd_multiplex_serial_ctrl_bench
bind vfd_multiplex_serial_ctrl vfd_mux_asserts #(
    .SIXTEENTH_CYC(SIXTEENTH_CYC), .TUBE_HALF_CYC(TUBE_HALF_CYC)) checker_i (
    .sys_clk(sys_clk), .srst(srst), .host_sclk(host_sclk), .host_cs_n(host_cs_n),
    .host_din(host_din), .general_out_a(general_out_a), .tube_shift_clock(tube_shift_clock),
    .tube_serial_out(tube_serial_out), .tube_latch_strobe(tube_latch_strobe),
    .tube_blank_out(tube_blank_out));
`default_nettype wire
